// File: bench/nsw_ctrl_tb.sv
// nsw_ctrl_tb: self-checking bench acting as the core in front of nsw_ctrl
// assumes the flash model answers reads; programming time shortened to 20 cycles
`timescale 1ns/1ns
module nsw_ctrl_tb
  import nsw_pkg::*;
();
  logic clk_sys, rst_n, tbl_rd_req, tbl_wr_req, seq_break, done_clr, mem_rd, done_flag, cpu_stall;
  nsw_sfr_req_t sfr;
  nsw_tbl_mode_t tbl_mode;
  logic [7:0] sfr_rdata;
  logic [20:0] wp_limit, mem_word_addr;
  logic [15:0] mem_rdata;
  nsw_pgm_t pgm;
  int err_total, checked, n0, e0, x0;

  nsw_ctrl #(.PROG_CYCLES(20)) u_nsw_ctrl (.clk_sys(clk_sys), .rst_n(rst_n), .sfr(sfr),
    .sfr_rdata(sfr_rdata), .tbl_rd_req(tbl_rd_req), .tbl_wr_req(tbl_wr_req), .tbl_mode(tbl_mode),
    .seq_break(seq_break), .done_clr(done_clr), .wp_limit(wp_limit), .mem_rd(mem_rd),
    .mem_word_addr(mem_word_addr), .mem_rdata(mem_rdata), .pgm(pgm), .done_flag(done_flag),
    .cpu_stall(cpu_stall));
  nsw_flash_model u_nsw_flash_model (.clk_sys(clk_sys), .rst_n(rst_n), .mem_rd(mem_rd),
    .mem_word_addr(mem_word_addr), .mem_rdata(mem_rdata), .pgm(pgm));

  // ---------------------------------------------------------------
  // clock and bus tasks
  // ---------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // one core cycle: inputs set 2 ns after an edge, held to the next edge
  task automatic drive(input logic w, input logic r, input logic [3:0] idx, input logic [7:0] d,
                       input logic trd, input logic twr, input nsw_tbl_mode_t m);
    sfr = '{wr: w, rd: r, idx: idx, wdata: d};
    tbl_rd_req = trd;
    tbl_wr_req = twr;
    tbl_mode = m;
    @(posedge clk_sys);
    #2;
  endtask
  task automatic idle();
    drive(1'b0, 1'b0, NSW_IDX_CTRL, 8'h00, 1'b0, 1'b0, NSW_PTR_KEEP);
  endtask
  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    drive(1'b1, 1'b0, idx, d, 1'b0, 1'b0, NSW_PTR_KEEP);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // register read: answer is registered, taken one cycle later
  task automatic rchk(input logic [3:0] idx, input logic [7:0] exp);
    drive(1'b0, 1'b1, idx, 8'h00, 1'b0, 1'b0, NSW_PTR_KEEP);
    chk(32'(sfr_rdata), 32'(exp));
  endtask
  task automatic set_ptr(input logic [21:0] p);
    wr(NSW_IDX_PTRU, {2'b00, p[21:16]});
    wr(NSW_IDX_PTRH, p[15:8]);
    wr(NSW_IDX_PTRL, p[7:0]);
  endtask
  // two keys then go as back-to-back writes; brk stands over the second key and the go write
  task automatic unlock(input logic [7:0] ctl, input logic brk);
    wr(NSW_IDX_CTRL, ctl);
    wr(NSW_IDX_KEY, NSW_KEY_FIRST);
    seq_break = brk;
    wr(NSW_IDX_KEY, NSW_KEY_SECOND);
    wr(NSW_IDX_CTRL, ctl | 8'h02);
    seq_break = 1'b0;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (cpu_stall !== 1'b0 && n < 200) begin
      idle();
      n++;
    end
    if (n >= 200) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, cpu_stall, 1'b0);
      close_out();
    end
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rchk(NSW_IDX_CTRL, 8'h00);
    rchk(NSW_IDX_PTRU, 8'h00);
    rchk(NSW_IDX_LATCH, 8'h00);
    wr(NSW_IDX_KEY, NSW_KEY_FIRST);
    rchk(NSW_IDX_KEY, 8'h00);
    wr(NSW_IDX_PTRU, 8'hFF);
    rchk(NSW_IDX_PTRU, 8'h3F);
    wr(NSW_IDX_LATCH, 8'h77);
    rchk(NSW_IDX_LATCH, 8'h77);
    $display("test reset done");
  endtask
  task automatic t_table_read_op();
    logic [21:0] p;
    logic [21:0] a;
    nsw_tbl_mode_t m;
    p = 22'h00_0101;
    set_ptr(p);
    for (int i = 0; i < 4; i++) begin
      m = nsw_tbl_mode_t'(i);
      a = (m == NSW_PTR_PREINC) ? p + 22'h00_0001 : p;
      p = (m == NSW_PTR_POSTDEC) ? p - 22'h00_0001 : (m == NSW_PTR_KEEP) ? p : p + 22'h00_0001;
      drive(1'b0, 1'b0, NSW_IDX_CTRL, 8'h00, 1'b1, 1'b0, m);
      chk(32'(mem_rd), 32'h1);
      chk(32'(mem_word_addr), 32'(a[21:1]));
      chk(32'(cpu_stall), 32'h1);
      idle();
      chk(32'(cpu_stall), 32'h0);
      rchk(NSW_IDX_LATCH, a[0] ? a[8:1] ^ 8'hA5 : a[8:1]);
      rchk(NSW_IDX_PTRL, p[7:0]);
    end
    set_ptr(22'h3F_FFFF);
    drive(1'b0, 1'b0, NSW_IDX_CTRL, 8'h00, 1'b1, 1'b0, NSW_PTR_POSTINC);
    idle();
    rchk(NSW_IDX_PTRU, 8'h20);
    rchk(NSW_IDX_PTRL, 8'h00);
    set_ptr(22'h25_0000);
    wr(NSW_IDX_LATCH, 8'h77);
    drive(1'b0, 1'b0, NSW_IDX_CTRL, 8'h00, 1'b1, 1'b0, NSW_PTR_KEEP);
    idle();
    rchk(NSW_IDX_LATCH, 8'h00);
    $display("test table read done");
  endtask
  task automatic t_write();
    set_ptr(22'h00_0040);
    wr(NSW_IDX_LATCH, 8'hC3);
    drive(1'b0, 1'b0, NSW_IDX_CTRL, 8'h00, 1'b0, 1'b1, NSW_PTR_POSTINC);
    wr(NSW_IDX_LATCH, 8'h3C);
    drive(1'b0, 1'b0, NSW_IDX_CTRL, 8'h00, 1'b0, 1'b1, NSW_PTR_POSTINC);
    rchk(NSW_IDX_PTRL, 8'h42);
    chk(u_nsw_flash_model.we_count, 0);
    n0 = u_nsw_flash_model.we_count;
    unlock(8'h84, 1'b0);
    chk(32'(cpu_stall), 32'h1);
    rchk(NSW_IDX_CTRL, 8'h8E);
    wr(NSW_IDX_CTRL, 8'h84);
    rchk(NSW_IDX_CTRL, 8'h8E);
    wait_idle();
    rchk(NSW_IDX_CTRL, 8'h84);
    chk(32'(done_flag), 32'h1);
    chk(u_nsw_flash_model.we_count - n0, 32);
    chk(32'(u_nsw_flash_model.row[0]), 32'h0000_00C3);
    chk(32'(u_nsw_flash_model.row[1]), 32'h0000_003C);
    chk(32'(u_nsw_flash_model.row[2]), 32'h0000_00FF);
    chk(32'(u_nsw_flash_model.last_addr), 32'h0000_005F);
    idle();
    chk(32'(done_flag), 32'h1);
    done_clr = 1'b1;
    idle();
    done_clr = 1'b0;
    idle();
    chk(32'(done_flag), 32'h0);
    set_ptr(22'h20_0000);
    n0 = u_nsw_flash_model.we_count;
    unlock(8'h44, 1'b0);
    wait_idle();
    chk(u_nsw_flash_model.we_count - n0, 32);
    chk(32'(u_nsw_flash_model.last_addr), 32'h0020_001F);
    $display("test flash write done");
  endtask
  task automatic t_erase();
    set_ptr(22'h00_01C5);
    n0 = u_nsw_flash_model.we_count;
    e0 = u_nsw_flash_model.erase_count;
    x0 = u_nsw_flash_model.ee_count;
    unlock(8'h94, 1'b0);
    chk(32'(cpu_stall), 32'h1);
    wait_idle();
    chk(u_nsw_flash_model.erase_count - e0, 1);
    chk(u_nsw_flash_model.we_count - n0, 0);
    chk(32'(u_nsw_flash_model.last_addr), 32'h0000_01C0);
    unlock(8'h14, 1'b0);
    wait_idle();
    chk(u_nsw_flash_model.ee_count - x0, 1);
    chk(u_nsw_flash_model.erase_count - e0, 1);
    $display("test erase done");
  endtask
  task automatic t_refuse();
    unlock(8'h80, 1'b0);
    chk(32'(cpu_stall), 32'h0);
    rchk(NSW_IDX_CTRL, 8'h80);
    unlock(8'h84, 1'b1);
    chk(32'(cpu_stall), 32'h0);
    rchk(NSW_IDX_CTRL, 8'h84);
    wp_limit = 21'h00_1000;
    set_ptr(22'h00_0800);
    unlock(8'h84, 1'b0);
    chk(32'(cpu_stall), 32'h0);
    rchk(NSW_IDX_CTRL, 8'h8C);
    wp_limit = 21'h00_0000;
    set_ptr(22'h25_0000);
    unlock(8'h44, 1'b0);
    chk(32'(cpu_stall), 32'h0);
    rchk(NSW_IDX_CTRL, 8'h4C);
    $display("test refusals done");
  endtask

  // ---------------------------------------------------------------
  // verdict and main sequence
  // ---------------------------------------------------------------
  task automatic close_out();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    sfr = '0;
    tbl_rd_req = 1'b0;
    tbl_wr_req = 1'b0;
    tbl_mode = NSW_PTR_KEEP;
    seq_break = 1'b0;
    done_clr = 1'b0;
    wp_limit = 21'h00_0000;
    err_total = 0;
    checked = 0;
    repeat (5) @(posedge clk_sys);
    #2;
    rst_n = 1'b1;
    t_reset();
    t_table_read_op();
    t_write();
    t_erase();
    t_refuse();
    close_out();
  end
endmodule

// File: bench/nsw_flash_model.sv
// nsw_flash_model: behavioural flash array on the far side of the nvm self write controller
// assumes word reads are answered while the read strobe stands, one clock domain
`timescale 1ns/1ns
module nsw_flash_model
  import nsw_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic mem_rd,
  input wire logic [20:0] mem_word_addr,
  output logic [15:0] mem_rdata,
  input wire nsw_pgm_t pgm
);
  logic [15:0] junk;
  logic [7:0] row [0:31];
  logic [21:0] last_addr;
  int we_count;
  int erase_count;
  int ee_count;

  // data only while the strobe stands; the controller samples at its closing edge
  assign mem_rdata = mem_rd ? {mem_word_addr[7:0] ^ 8'hA5, mem_word_addr[7:0]} : junk;

  // answer timing, byte capture and operation counts
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      junk <= 16'h0000;
      last_addr <= 22'h00_0000;
      we_count <= 0;
      erase_count <= 0;
      ee_count <= 0;
    end else begin
      junk <= junk + 16'h1357;
      if (pgm.byte_we) begin
        row[pgm.addr[4:0]] <= pgm.data;
        we_count <= we_count + 1;
      end
      if (pgm.byte_we || pgm.erase_start || pgm.ee_start) begin
        last_addr <= pgm.addr;
      end
      if (pgm.erase_start) begin
        erase_count <= erase_count + 1;
      end
      if (pgm.ee_start) begin
        ee_count <= ee_count + 1;
      end
    end
  end
endmodule

// File: verilog/nsw_ctrl.sv
// nsw_ctrl: nvm self write controller, table pointer, latch, unlock and timer
// assumes the core issues one register access or one table op per cycle
// Operation
// R01 - unlock register stores nothing, reads zero
// R02 - region field routes eeprom, flash, config space
// R03 - erase select turns flash go into erase
// R04 - program or erase only with write enable
// R05 - error set on go, cleared on success
// R06 - firmware only sets go; hardware clears it
// R07 - eeprom erase-write; flash write or erase
// R08 - done flag set on completion, firmware clears
// R09 - byte latch between memory and data
// R10 - three bytes form 22-bit pointer
// R11 - reads use 22 bits; updates only 21
// R12 - table write fills holding byte only
// R13 - flash write copies block at upper bits
// R14 - four pointer modes for table ops
// R15 - stall core during table read only
// R16 - address lsb picks word high byte
// R17 - core writes 55h, AAh, then go
// R18 - broken unlock timing cancels the operation
// R19 - stall core until timer ends operation
// R20 - software masks interrupts around unlock
// R21 - erase clears row by bits 21:6
// R22 - core sets region, enable, erase first
// R23 - protected target: no operation, error set
// R24 - reserved space reads zero, writes error
// R25 - programming time is a cycle parameter
`timescale 1ns/1ns
module nsw_ctrl
  import nsw_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = NSW_PROG_CYCLES_DEF // [R25]
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire nsw_sfr_req_t sfr,
  output logic [7:0] sfr_rdata,
  input wire logic tbl_rd_req,
  input wire logic tbl_wr_req,
  input wire nsw_tbl_mode_t tbl_mode,
  input wire logic seq_break,
  input wire logic done_clr,
  input wire logic [20:0] wp_limit,
  output logic mem_rd,
  output logic [20:0] mem_word_addr,
  input wire logic [15:0] mem_rdata,
  output nsw_pgm_t pgm,
  output logic done_flag,
  output logic cpu_stall
);

  typedef struct packed {
    nsw_state_t st;
    logic [21:0] ptr;
    logic [7:0] latch;
    logic [1:0] region;
    logic erase;
    logic err;
    logic write_enable;
    logic go;
    logic done;
    logic [1:0] key_step;
    logic [7:0] rdata;
    logic mem_rd;
    logic [20:0] mem_addr;
    logic rd_lsb;
    logic rd_ok;
    logic [4:0] idx;
    logic strm_vld;
    logic [21:0] strm_addr;
    logic [31:0] cnt;
    nsw_pgm_t pgm;
  } nsw_ctrl_t;

  nsw_ctrl_t c_reg;
  nsw_ctrl_t c_next;
  logic hold_we;
  logic [4:0] hold_waddr;
  logic hold_fill;
  logic [7:0] hold_rdata;
  logic [21:0] acc_addr;
  logic [21:0] ptr_after;
  logic target_ok;

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  // pointer step touching only the low 21 bits
  function automatic logic [21:0] ptr_step(input logic [21:0] p, input logic dn);
    logic [20:0] low;
    low = dn ? (p[20:0] - 21'h1) : (p[20:0] + 21'h1);
    ptr_step = {p[21], low}; // [R11]
  endfunction

  // readable space: flash, user ids, config, ids
  function automatic logic readable(input logic [21:0] a);
    readable = (a <= NSW_PFM_LAST) || ((a >= NSW_UID_FIRST) && (a <= NSW_UID_LAST))
      || ((a >= NSW_CFG_FIRST) && (a <= NSW_CFG_LAST))
      || (a >= NSW_DID_FIRST); // [R24]
  endfunction

  // access address and pointer after a table op
  always_comb begin
    acc_addr = (tbl_mode == NSW_PTR_PREINC) ? ptr_step(c_reg.ptr, 1'b0) : c_reg.ptr; // [R14]
    case (tbl_mode)
      NSW_PTR_POSTINC: ptr_after = ptr_step(c_reg.ptr, 1'b0);
      NSW_PTR_POSTDEC: ptr_after = ptr_step(c_reg.ptr, 1'b1);
      NSW_PTR_PREINC: ptr_after = acc_addr;
      default: ptr_after = c_reg.ptr;
    endcase
  end

  // target check for a go request
  always_comb begin
    case (c_reg.region) // [R02]
      NSW_REGION_EE: target_ok = 1'b1;
      NSW_REGION_PFM: target_ok = (c_reg.ptr <= NSW_PFM_LAST)
        && (c_reg.ptr[20:0] >= wp_limit); // [R23] [R24]
      // region x1: only user id and config space are writable
      default: target_ok = ((c_reg.ptr >= NSW_UID_FIRST) && (c_reg.ptr <= NSW_UID_LAST))
        || ((c_reg.ptr >= NSW_CFG_FIRST) && (c_reg.ptr <= NSW_CFG_LAST)); // [R24]
    endcase
  end

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb begin
    c_next = c_reg;
    c_next.mem_rd = 1'b0;
    c_next.strm_vld = 1'b0;
    c_next.pgm.byte_we = 1'b0;
    c_next.pgm.erase_start = 1'b0;
    c_next.pgm.ee_start = 1'b0;
    hold_we = 1'b0;
    hold_waddr = acc_addr[4:0];
    hold_fill = 1'b0;

    // register read data, unlock and reserved bits read zero
    if (sfr.rd) begin
      case (sfr.idx)
        NSW_IDX_CTRL: c_next.rdata = {c_reg.region, 1'b0, c_reg.erase, c_reg.err,
          c_reg.write_enable, c_reg.go, 1'b0};
        NSW_IDX_LATCH: c_next.rdata = c_reg.latch;
        NSW_IDX_PTRU: c_next.rdata = {2'h0, c_reg.ptr[21:16]};
        NSW_IDX_PTRH: c_next.rdata = c_reg.ptr[15:8];
        NSW_IDX_PTRL: c_next.rdata = c_reg.ptr[7:0];
        default: c_next.rdata = NSW_BYTE_RESET; // [R01]
      endcase
    end

    if (done_clr) begin
      c_next.done = 1'b0;
    end

    // streamed holding bytes leave one cycle after their read
    if (c_reg.strm_vld) begin
      c_next.pgm.byte_we = 1'b1;
      c_next.pgm.data = hold_rdata;
      c_next.pgm.addr = c_reg.strm_addr;
    end

    case (c_reg.st)
      NSW_ST_IDLE: begin
        if (sfr.wr) begin
          c_next.key_step = 2'h0; // [R18]
          case (sfr.idx)
            NSW_IDX_KEY: begin
              if (sfr.wdata == NSW_KEY_FIRST) begin
                c_next.key_step = 2'h1;
              end else if ((sfr.wdata == NSW_KEY_SECOND) && (c_reg.key_step == 2'h1)) begin
                c_next.key_step = 2'h2;
              end
            end
            NSW_IDX_CTRL: begin
              c_next.region = sfr.wdata[NSW_CTL_REG_HI:NSW_CTL_REG_LO];
              c_next.erase = sfr.wdata[NSW_CTL_ERASE];
              c_next.write_enable = sfr.wdata[NSW_CTL_WRITE_ENABLE];
              c_next.err = c_reg.err & sfr.wdata[NSW_CTL_ERR];
              // go only starts after an unbroken unlock with writes enabled
              if (sfr.wdata[NSW_CTL_GO] && (c_reg.key_step == 2'h2) && c_reg.write_enable
                  && !seq_break) begin // [R04] [R18] [R06]
                c_next.err = 1'b1; // [R05] [R23]
                if (target_ok) begin
                  c_next.go = 1'b1;
                  c_next.cnt = 32'h0000_0000;
                  if (c_reg.region == NSW_REGION_EE) begin
                    c_next.pgm.ee_start = 1'b1; // [R07]
                    c_next.st = NSW_ST_TIMER;
                  end else if ((c_reg.region == NSW_REGION_PFM) && c_reg.erase) begin
                    c_next.pgm.erase_start = 1'b1; // [R03] [R07]
                    c_next.pgm.addr = {c_reg.ptr[21:6], NSW_ROW_ZERO}; // [R21]
                    c_next.st = NSW_ST_TIMER;
                  end else begin
                    c_next.idx = 5'h00; // [R13]
                    c_next.st = NSW_ST_STREAM;
                  end
                end
              end
            end
            NSW_IDX_LATCH: c_next.latch = sfr.wdata; // [R09]
            NSW_IDX_PTRU: c_next.ptr[21:16] = sfr.wdata[5:0]; // [R10]
            NSW_IDX_PTRH: c_next.ptr[15:8] = sfr.wdata;
            NSW_IDX_PTRL: c_next.ptr[7:0] = sfr.wdata;
            default: c_next.key_step = 2'h0;
          endcase
        end else if (tbl_rd_req) begin
          c_next.mem_rd = 1'b1;
          c_next.mem_addr = acc_addr[21:1]; // [R16]
          c_next.rd_lsb = acc_addr[0];
          c_next.rd_ok = readable(acc_addr); // [R11]
          c_next.ptr = ptr_after; // [R14]
          c_next.key_step = 2'h0;
          c_next.st = NSW_ST_RD; // [R15]
        end else if (tbl_wr_req) begin
          hold_we = 1'b1; // [R12]
          c_next.ptr = ptr_after; // [R14]
          c_next.key_step = 2'h0;
        end
        if (seq_break) begin
          c_next.key_step = 2'h0; // [R18]
        end
      end
      NSW_ST_RD: begin
        // byte of the word into the latch, zero outside mapped space
        if (!c_reg.rd_ok) begin
          c_next.latch = NSW_BYTE_RESET; // [R24]
        end else if (c_reg.rd_lsb) begin
          c_next.latch = mem_rdata[15:8]; // [R16]
        end else begin
          c_next.latch = mem_rdata[7:0];
        end
        c_next.st = NSW_ST_IDLE;
      end
      NSW_ST_STREAM: begin
        c_next.strm_vld = 1'b1;
        c_next.strm_addr = {c_reg.ptr[21:NSW_HOLD_AW], c_reg.idx}; // [R13]
        c_next.idx = c_reg.idx + 5'h01;
        if (c_reg.idx == NSW_HOLD_LAST) begin
          c_next.st = NSW_ST_TIMER;
        end
      end
      NSW_ST_TIMER: begin
        // last streamed byte already read, holding block returns to erased
        hold_fill = c_reg.strm_vld;
        c_next.cnt = c_reg.cnt + 32'h0000_0001;
        if (c_reg.cnt >= (PROG_CYCLES - 32'h0000_0001)) begin // [R19] [R25]
          c_next.go = 1'b0; // [R06]
          c_next.err = 1'b0; // [R05]
          c_next.done = 1'b1; // [R08]
          c_next.st = NSW_ST_IDLE;
        end
      end
      default: c_next.st = NSW_ST_IDLE;
    endcase
  end

  // -------------------------------------------------------------
  // registers; write enable and go clear at power-up
  // -------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      c_reg <= '0; // [R04]
      c_reg.st <= NSW_ST_IDLE;
      c_reg.ptr <= NSW_PTR_RESET;
    end else begin
      c_reg <= c_next;
    end
  end

  // holding registers
  nsw_hold_mem u_hold (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .we(hold_we),
    .waddr(hold_waddr),
    .wdata(c_reg.latch),
    .raddr(c_reg.idx),
    .fill(hold_fill),
    .rdata(hold_rdata)
  );

  // outputs
  assign sfr_rdata = c_reg.rdata;
  assign mem_rd = c_reg.mem_rd;
  assign mem_word_addr = c_reg.mem_addr;
  assign pgm = c_reg.pgm;
  assign done_flag = c_reg.done;
  assign cpu_stall = (c_reg.st != NSW_ST_IDLE); // [R15] [R19]

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  key_reads_zero_a: assert property (sfr.rd && (sfr.idx == NSW_IDX_KEY) |=> // [R01]
    (sfr_rdata == 8'h00)) else $error("unlock register read not zero");
  go_needs_write_enable_a: assert property ($rose(c_reg.go) |-> $past(c_reg.write_enable)) // [R04]
    else $error("go set without write enable");
  go_sets_err_a: assert property ($rose(c_reg.go) |-> c_reg.err) // [R05]
    else $error("error flag not set with go");
  go_hw_clear_a: assert property ($fell(c_reg.go) |-> $past(c_reg.st == NSW_ST_TIMER)) // [R06]
    else $error("go cleared outside completion");
  done_on_end_a: assert property ((c_reg.st == NSW_ST_IDLE) // [R08]
    && $past(c_reg.st == NSW_ST_TIMER) |-> done_flag)
    else $error("completion without done flag");
  end_clears_a: assert property ($fell(cpu_stall) && $past(c_reg.st == NSW_ST_TIMER) |-> // [R05]
    !c_reg.go && !c_reg.err && c_reg.done) else $error("completion flags wrong");
  read_stall_a: assert property ((c_reg.st == NSW_ST_IDLE) && !sfr.wr && tbl_rd_req |=> // [R15]
    cpu_stall ##1 !cpu_stall) else $error("table read stall not one cycle");
  ptr_top_kept_a: assert property ((c_reg.st == NSW_ST_IDLE) && !sfr.wr // [R11]
    && (tbl_rd_req || tbl_wr_req) |=> c_reg.ptr[21] == $past(c_reg.ptr[21]))
    else $error("pointer top bit changed by table op");
  no_unlock_a: assert property ((c_reg.st == NSW_ST_IDLE) && sfr.wr && !c_reg.go // [R18]
    && (sfr.idx == NSW_IDX_CTRL) && (c_reg.key_step != 2'h2) |=> !c_reg.go)
    else $error("go set without unlock");
  erase_row_a: assert property (pgm.erase_start |-> (pgm.addr[5:0] == 6'h00) // [R21]
    && cpu_stall) else $error("erase row address not aligned");
  busy_stall_a: assert property (c_reg.go |-> cpu_stall) // [R19]
    else $error("core not stalled during operation");
  stream_len_a: assert property ($rose(c_reg.st == NSW_ST_STREAM) |-> // [R13]
    (c_reg.st == NSW_ST_STREAM) [*8]) else $error("stream shorter than expected");

  erase_seen_c: cover property (pgm.erase_start);
  ee_seen_c: cover property (pgm.ee_start);
  write_done_c: cover property (pgm.byte_we ##[1:40] $rose(done_flag));
  read_seen_c: cover property (c_reg.st == NSW_ST_RD);

endmodule

// File: verilog/nsw_hold_mem.sv
// nsw_hold_mem: holding register block between table writes and a flash write
// assumes one write and one read per cycle; fill sets every byte back to erased
`timescale 1ns/1ns
module nsw_hold_mem
  import nsw_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [4:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [4:0] raddr,
  input wire logic fill,
  output logic [7:0] rdata
);

  typedef struct packed {
    logic [NSW_HOLD_DEPTH-1:0][7:0] ent;
    logic [7:0] rdata;
  } nsw_hold_t;

  nsw_hold_t hold_reg;
  nsw_hold_t hold_next;

  // -------------------------------------------------------------
  // next state: registered read, fill, byte write
  // -------------------------------------------------------------
  always_comb begin
    hold_next = hold_reg;
    hold_next.rdata = hold_reg.ent[raddr];
    for (int i = 0; i < NSW_HOLD_DEPTH; i++) begin
      if (fill) begin
        hold_next.ent[i] = NSW_HOLD_RESET;
      end else if (we && (waddr == i[4:0])) begin
        hold_next.ent[i] = wdata;
      end
    end
  end

  // registers, erased value after reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hold_reg <= {(NSW_HOLD_DEPTH + 1){NSW_HOLD_RESET}};
    end else begin
      hold_reg <= hold_next;
    end
  end

  assign rdata = hold_reg.rdata;

endmodule

// File: verilog/nsw_pkg.sv
// nsw_pkg: constants, types and register layout of the nvm self write controller
// assumes one core clock domain; every input of the block except mem_rdata is driven by core-side logic
package nsw_pkg;

  // ---------------------------------------------------------------
  // register indices in the special function space
  // ---------------------------------------------------------------
  localparam logic [3:0] NSW_IDX_CTRL = 4'h0; // nvm_control
  localparam logic [3:0] NSW_IDX_KEY = 4'h1;  // nvm_unlock_key
  localparam logic [3:0] NSW_IDX_LATCH = 4'h2; // table_data_latch
  localparam logic [3:0] NSW_IDX_PTRU = 4'h3; // table_pointer_upper
  localparam logic [3:0] NSW_IDX_PTRH = 4'h4; // table_pointer_high
  localparam logic [3:0] NSW_IDX_PTRL = 4'h5; // table_pointer_low

  // ---------------------------------------------------------------
  // nvm_control field positions and codes
  // ---------------------------------------------------------------
  localparam int NSW_CTL_REG_HI = 7;
  localparam int NSW_CTL_REG_LO = 6;
  localparam int NSW_CTL_ERASE = 4;
  localparam int NSW_CTL_ERR = 3;
  localparam int NSW_CTL_WRITE_ENABLE = 2;
  localparam int NSW_CTL_GO = 1;
  localparam logic [1:0] NSW_REGION_EE = 2'h0;
  localparam logic [1:0] NSW_REGION_PFM = 2'h2;
  localparam logic [7:0] NSW_KEY_FIRST = 8'h55;
  localparam logic [7:0] NSW_KEY_SECOND = 8'hAA;

  // ---------------------------------------------------------------
  // address map of the 22-bit pointer space
  // ---------------------------------------------------------------
  localparam logic [21:0] NSW_PFM_LAST = 22'h01_FFFF;
  localparam logic [21:0] NSW_UID_FIRST = 22'h20_0000;
  localparam logic [21:0] NSW_UID_LAST = 22'h20_000F;
  localparam logic [21:0] NSW_CFG_FIRST = 22'h30_0000;
  localparam logic [21:0] NSW_CFG_LAST = 22'h30_000B;
  localparam logic [21:0] NSW_DID_FIRST = 22'h3F_FFFC;
  localparam logic [21:0] NSW_DID_LAST = 22'h3F_FFFF;

  // ---------------------------------------------------------------
  // holding block, row and reset values
  // ---------------------------------------------------------------
  localparam int NSW_HOLD_AW = 5;
  localparam int NSW_HOLD_DEPTH = 32;
  localparam logic [4:0] NSW_HOLD_LAST = 5'h1F;
  localparam logic [7:0] NSW_HOLD_RESET = 8'hFF;
  localparam logic [5:0] NSW_ROW_ZERO = 6'h00;
  localparam logic [7:0] NSW_BYTE_RESET = 8'h00;
  localparam logic [21:0] NSW_PTR_RESET = 22'h00_0000;

  // ---------------------------------------------------------------
  // timing: programming time and derived cycle count
  // ---------------------------------------------------------------
  localparam int NSW_PROG_TIME_US = 2000;
  localparam int NSW_CLK_MHZ = 50;
  localparam int NSW_PROG_CYCLES_DEF = NSW_PROG_TIME_US * NSW_CLK_MHZ;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    NSW_PTR_KEEP = 2'h0,
    NSW_PTR_POSTINC = 2'h1,
    NSW_PTR_POSTDEC = 2'h2,
    NSW_PTR_PREINC = 2'h3
  } nsw_tbl_mode_t;

  typedef enum logic [4:0] {
    NSW_ST_IDLE = 5'h01,
    NSW_ST_RD = 5'h02,
    NSW_ST_STREAM = 5'h04,
    NSW_ST_TIMER = 5'h08,
    NSW_ST_SPARE = 5'h10
  } nsw_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] idx;
    logic [7:0] wdata;
  } nsw_sfr_req_t;

  typedef struct packed {
    logic byte_we;
    logic [21:0] addr;
    logic [7:0] data;
    logic erase_start;
    logic ee_start;
  } nsw_pgm_t;

endpackage
